// File: src/sdp_dram_pins.sv
/*
  Device-side pin logic of a separate-I/O eight-bank DDR DRAM: command capture
  and decode, mode register, write data capture on the write data clock, a small
  bank memory, and read data return with free-running read data clocks.
  Assumes core_clk_in is the true phase of the command clock pair, commands are
  synchronous to it, and write_data_clk_in may stop between bursts.
*/
`timescale 1ns/1ps
module sdp_dram_pins #(
  parameter int MEM_AW = 6
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic decoder_enable_n_in,
  input wire logic write_cmd_n_in,
  input wire logic refresh_cmd_n_in,
  input wire logic [sdp_pkg::BANK_W-1:0] bank_select_in,
  input wire logic [sdp_pkg::ADDR_W-1:0] row_col_addr_in,
  input wire logic write_data_clk_in,
  input wire logic [sdp_pkg::DATA_W-1:0] write_data_in,
  input wire logic write_mask_in,
  output logic [sdp_pkg::DATA_W-1:0] read_data_out,
  output logic read_valid_out,
  output logic [1:0] read_data_clk_out,
  output logic [1:0] read_data_clk_n_out
);
  localparam int IDX_W = sdp_pkg::BANK_W + MEM_AW;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_BURST = 1'b1
  } sdp_rd_state_t;

  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_DATA = 1'b1
  } sdp_wr_state_t;

  // ---------------- command capture and decode ----------------
  sdp_pkg::sdp_cmd_pins_t cap_q;
  sdp_pkg::sdp_cmd_pins_t cmd_q;
  sdp_pkg::sdp_cmd_t cmd_kind;

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cap_q <= sdp_pkg::CMD_PINS_RST;
      cmd_q <= sdp_pkg::CMD_PINS_RST;
    end else begin
      cap_q <= '{dec_en_n: decoder_enable_n_in, wr_n: write_cmd_n_in,
                 ref_n: refresh_cmd_n_in, bank: bank_select_in,
                 addr: row_col_addr_in};
      cmd_q <= cap_q;
    end
  end

  always_comb begin
    if (cmd_q.dec_en_n) begin
      cmd_kind = sdp_pkg::SDP_CMD_NOP;
    end else begin
      unique case ({cmd_q.wr_n, cmd_q.ref_n})
        2'b11: cmd_kind = sdp_pkg::SDP_CMD_READ;
        2'b01: cmd_kind = sdp_pkg::SDP_CMD_WRITE;
        2'b10: cmd_kind = sdp_pkg::SDP_CMD_REFRESH;
        2'b00: cmd_kind = sdp_pkg::SDP_CMD_MRS;
      endcase
    end
  end

  // ---------------- mode register ----------------
  logic [1:0] bl_code_q;
  logic [1:0] bl_field;
  logic [3:0] bl_words;

  assign bl_field = cmd_q.addr[sdp_pkg::MRS_BL_LSB +: 2];

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bl_code_q <= sdp_pkg::BL_CODE_RST;
    end else if (cmd_kind == sdp_pkg::SDP_CMD_MRS && bl_field != 2'h3) begin
      bl_code_q <= bl_field;
    end
  end

  always_comb begin
    unique case (bl_code_q)
      sdp_pkg::BL_CODE_4: bl_words = sdp_pkg::BL_WORDS_4;
      sdp_pkg::BL_CODE_8: bl_words = sdp_pkg::BL_WORDS_8;
      default: bl_words = sdp_pkg::BL_WORDS_2;
    endcase
  end

  // ---------------- storage ----------------
  logic [sdp_pkg::DATA_W-1:0] mem [2**IDX_W];
  logic [IDX_W-1:0] cmd_idx;
  logic mem_we;
  logic [IDX_W-1:0] mem_widx;
  logic [sdp_pkg::DATA_W-1:0] mem_wdata;

  assign cmd_idx = {cmd_q.bank, cmd_q.addr[MEM_AW-1:0]};

  always_ff @(posedge core_clk_in) begin
    if (mem_we) begin
      mem[mem_widx] <= mem_wdata;
    end
  end

  // ---------------- write data capture, link domain ----------------
  logic [sdp_pkg::DATA_W-1:0] rise_word_q;
  logic rise_mask_q;
  sdp_pkg::sdp_wr_pair_t hold_q;
  logic link_tgl_q;

  always_ff @(posedge write_data_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rise_word_q <= '0;
      rise_mask_q <= 1'b0;
    end else begin
      rise_word_q <= write_data_in;
      rise_mask_q <= write_mask_in;
    end
  end

  // falling edge closes the pair and publishes it by toggle
  always_ff @(negedge write_data_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_q <= '0;
      link_tgl_q <= 1'b0;
    end else begin
      hold_q <= '{word1: write_data_in, mask1: write_mask_in,
                  word0: rise_word_q, mask0: rise_mask_q};
      link_tgl_q <= ~link_tgl_q;
    end
  end

  // ---------------- crossing into the core domain ----------------
  logic tgl_s;
  logic seen_q;
  logic pair_pending;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  sdp_pkg::sdp_wr_pair_t buf_out;

  sdp_sync #(
    .W(1)
  ) u_tgl_sync (
    .clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .d_in(link_tgl_q),
    .q_out(tgl_s)
  );

  assign pair_pending = tgl_s ^ seen_q;

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      seen_q <= 1'b0;
    end else if (pair_pending && buf_in_ready) begin
      seen_q <= tgl_s;
    end
  end

  sdp_buf2 #(
    .W(sdp_pkg::PAIR_W)
  ) u_wr_buf (
    .clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(pair_pending),
    .in_ready_out(buf_in_ready),
    .in_data_in(hold_q),
    .out_valid_out(buf_out_valid),
    .out_ready_in(buf_out_ready),
    .out_data_out(buf_out)
  );

  // ---------------- write burst engine ----------------
  sdp_wr_state_t wr_state_q;
  logic [IDX_W-1:0] wr_idx_q;
  logic [3:0] wr_left_q;
  logic half_q;
  logic [sdp_pkg::DATA_W-1:0] cur_word;
  logic cur_mask;

  assign cur_word = half_q ? buf_out.word1 : buf_out.word0;
  assign cur_mask = half_q ? buf_out.mask1 : buf_out.mask0;
  // pairs that arrive with no write open are drained and dropped
  assign buf_out_ready = (wr_state_q == WR_IDLE) | half_q;
  assign mem_we = (wr_state_q == WR_DATA) & buf_out_valid & ~cur_mask;
  assign mem_widx = wr_idx_q;
  assign mem_wdata = cur_word;

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_state_q <= WR_IDLE;
      wr_idx_q <= '0;
      wr_left_q <= 4'h0;
      half_q <= 1'b0;
    end else begin
      unique case (wr_state_q)
        WR_IDLE: begin
          half_q <= 1'b0;
          if (cmd_kind == sdp_pkg::SDP_CMD_WRITE) begin
            wr_state_q <= WR_DATA;
            wr_idx_q <= cmd_idx;
            wr_left_q <= bl_words;
          end
        end
        WR_DATA: begin
          // runs to its end even when the decoder is disabled
          if (buf_out_valid) begin
            half_q <= ~half_q;
            wr_idx_q <= {wr_idx_q[IDX_W-1 -: sdp_pkg::BANK_W],
                         wr_idx_q[MEM_AW-1:0] + {{(MEM_AW-1){1'b0}}, 1'b1}};
            wr_left_q <= wr_left_q - 4'h1;
            if (wr_left_q == 4'h1) begin
              wr_state_q <= WR_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ---------------- read burst engine ----------------
  sdp_rd_state_t rd_state_q;
  logic [IDX_W-1:0] rd_idx_q;
  logic [3:0] rd_left_q;

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_state_q <= RD_IDLE;
      rd_idx_q <= '0;
      rd_left_q <= 4'h0;
    end else begin
      unique case (rd_state_q)
        RD_IDLE: begin
          if (cmd_kind == sdp_pkg::SDP_CMD_READ) begin
            rd_state_q <= RD_BURST;
            rd_idx_q <= cmd_idx;
            rd_left_q <= bl_words;
          end
        end
        RD_BURST: begin
          rd_idx_q <= {rd_idx_q[IDX_W-1 -: sdp_pkg::BANK_W],
                       rd_idx_q[MEM_AW-1:0] + {{(MEM_AW-1){1'b0}}, 1'b1}};
          rd_left_q <= rd_left_q - 4'h1;
          if (rd_left_q == 4'h1) begin
            rd_state_q <= RD_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------- read outputs ----------------
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      read_data_out <= '0;
      read_valid_out <= 1'b0;
    end else if (rd_state_q == RD_BURST) begin
      read_data_out <= mem[rd_idx_q];
      read_valid_out <= 1'b1;
    end else begin
      read_data_out <= '0;
      read_valid_out <= 1'b0;
    end
  end

  // one clock edge per word, so data can change on every edge while valid holds high for the whole burst
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_rclk
      always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          read_data_clk_out[p] <= 1'b0;
          read_data_clk_n_out[p] <= 1'b1;
        end else begin
          read_data_clk_out[p] <= ~read_data_clk_out[p];
          read_data_clk_n_out[p] <= ~read_data_clk_n_out[p];
        end
      end
    end
  endgenerate

endmodule

// File: inc/sdp_pkg.sv
/*
  Shared constants and types for the separate-I/O DRAM pin interface model.
  Assumes every user refers to names as sdp_pkg::name, with no import.
*/
package sdp_pkg;

  localparam int ADDR_W = 20;
  localparam int BANK_W = 3;
  localparam int DATA_W = 18;
  localparam int HALF_W = 9;

  // mode register: burst length code position in row_col_addr
  localparam int MRS_BL_LSB = 3;
  localparam logic [1:0] BL_CODE_2 = 2'h0;
  localparam logic [1:0] BL_CODE_4 = 2'h1;
  localparam logic [1:0] BL_CODE_8 = 2'h2;
  localparam logic [1:0] BL_CODE_RST = 2'h0;

  localparam logic [3:0] BL_WORDS_2 = 4'h2;
  localparam logic [3:0] BL_WORDS_4 = 4'h4;
  localparam logic [3:0] BL_WORDS_8 = 4'h8;

  typedef enum logic [2:0] {
    SDP_CMD_NOP = 3'h0,
    SDP_CMD_READ = 3'h1,
    SDP_CMD_WRITE = 3'h2,
    SDP_CMD_REFRESH = 3'h3,
    SDP_CMD_MRS = 3'h4
  } sdp_cmd_t;

  typedef struct packed {
    logic dec_en_n;
    logic wr_n;
    logic ref_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } sdp_cmd_pins_t;

  localparam sdp_cmd_pins_t CMD_PINS_RST = '{dec_en_n: 1'b1, wr_n: 1'b1, ref_n: 1'b1,
                                              bank: 3'h0, addr: 20'h00000};

  // one write data clock period: rising-edge word first
  typedef struct packed {
    logic [DATA_W-1:0] word1;
    logic mask1;
    logic [DATA_W-1:0] word0;
    logic mask0;
  } sdp_wr_pair_t;

  localparam int PAIR_W = 2 * DATA_W + 2;

endpackage

// File: src/sdp_sync.sv
/*
  Two flip-flop level synchroniser.
  Assumes the input is a level that stays put for more than two destination cycles.
*/
`timescale 1ns/1ps
module sdp_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= '0;
      q_out <= '0;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule

// File: src/sdp_buf2.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes both sides run on one clock; full and empty are exact.
*/
`timescale 1ns/1ps
module sdp_buf2 #(
  parameter int W = 8
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  logic [W-1:0] slot_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_out = (cnt_q != 2'h2);
  assign out_valid_out = (cnt_q != 2'h0);
  assign out_data_out = slot_q[rd_ptr_q];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      slot_q[wr_ptr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// File: dv/sdp_dram_pins_sva.sv
/*
  Checker for the DRAM pin block: read return timing and read data clocks.
  Assumes it is bound to sdp_dram_pins and sees only its ports.
*/
`timescale 1ns/1ps
module sdp_dram_pins_sva (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic decoder_enable_n_in,
  input wire logic write_cmd_n_in,
  input wire logic refresh_cmd_n_in,
  input wire logic read_valid_out,
  input wire logic [1:0] read_data_clk_out,
  input wire logic [1:0] read_data_clk_n_out
);
  default clocking dcb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);
  logic rd_cmd;
  logic [3:0] vcnt_q;
  assign rd_cmd = !decoder_enable_n_in && write_cmd_n_in && refresh_cmd_n_in;
  // length of the current valid run
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      vcnt_q <= 4'h0;
    end else if (read_valid_out) begin
      vcnt_q <= vcnt_q + 4'h1;
    end else begin
      vcnt_q <= 4'h0;
    end
  end
  clk_toggle_a: assert property (
    rstn_in |=> read_data_clk_out == ~$past(read_data_clk_out)) else $error("clock stuck");
  clk_compl_a: assert property (
    read_data_clk_n_out == ~read_data_clk_out) else $error("clock pair mismatch");
  clk_pair_a: assert property (
    read_data_clk_out[0] == read_data_clk_out[1]) else $error("read clocks skewed");
  rd_lat_a: assert property (
    rd_cmd |-> ##3 !read_valid_out ##1 read_valid_out) else $error("read latency wrong");
  rd_cause_a: assert property (
    $rose(read_valid_out) |-> $past(rd_cmd, 4)) else $error("valid without read");
  valid_run_a: assert property (
    $rose(read_valid_out) |=> read_valid_out) else $error("valid too short");
  len_set_a: assert property (
    $fell(read_valid_out) |-> vcnt_q inside {4'h2, 4'h4, 4'h8}) else $error("bad burst");
  len_max_a: assert property (
    vcnt_q <= 4'h8) else $error("burst too long");
endmodule

bind sdp_dram_pins sdp_dram_pins_sva sdp_dram_pins_sva_inst (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in),
  .decoder_enable_n_in(decoder_enable_n_in), .write_cmd_n_in(write_cmd_n_in),
  .refresh_cmd_n_in(refresh_cmd_n_in), .read_valid_out(read_valid_out),
  .read_data_clk_out(read_data_clk_out), .read_data_clk_n_out(read_data_clk_n_out));

// File: dv/sdp_ctl_model.sv
/*
  Controller model: drives command pins and the write data link.
  Assumes the bench calls its tasks; the write clock stands low between pairs.
*/
`timescale 1ns/1ps
module sdp_ctl_model (
  input wire logic clk_in,
  output sdp_pkg::sdp_cmd_pins_t cmd_out,
  output logic wclk_out,
  output logic [17:0] wdata_out,
  output logic wmask_out
);
  initial begin
    cmd_out = sdp_pkg::CMD_PINS_RST;
    wclk_out = 1'b0;
    wdata_out = 18'h0;
    wmask_out = 1'b0;
  end
  // c is {enable_n, write_n, refresh_n}
  task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [19:0] a);
    @(posedge clk_in);
    cmd_out <= {c, b, a};
    @(posedge clk_in);
    cmd_out <= {3'h7, ~b, ~a};
  endtask
  task automatic pair(input logic [17:0] d0, d1, input logic m0, m1);
    wdata_out = d0;
    wmask_out = m0;
    #20 wclk_out = 1'b1;
    #20 wdata_out = d1;
    wmask_out = m1;
    #20 wclk_out = 1'b0;
    #20 wdata_out = ~d1;
    wmask_out = ~m1;
  endtask
endmodule

// File: dv/tb.sv
/*
  Self-checking bench for the DRAM pin block.
  Assumes the controller model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
module tb;
  localparam logic [17:0] A = 18'h2A5C3, B = 18'h15A3C, C = 18'h3F00F, D = 18'h00FF0;
  localparam logic [17:0] E = 18'h12345, F = 18'h3CDEF, G = 18'h0F0F0, H = 18'h30303;
  logic clk, rstn, wclk, wm, rv;
  logic [17:0] wd, rd_q;
  logic [1:0] qk, qkn;
  sdp_pkg::sdp_cmd_pins_t pins;
  logic [17:0] got[$];
  int error_cnt = 0;
  int check_count = 0;
  sdp_dram_pins #(.MEM_AW(6)) sdp_dram_pins_inst (
    .core_clk_in(clk), .rstn_in(rstn), .decoder_enable_n_in(pins.dec_en_n),
    .write_cmd_n_in(pins.wr_n), .refresh_cmd_n_in(pins.ref_n), .bank_select_in(pins.bank),
    .row_col_addr_in(pins.addr), .write_data_clk_in(wclk), .write_data_in(wd),
    .write_mask_in(wm), .read_data_out(rd_q), .read_valid_out(rv),
    .read_data_clk_out(qk), .read_data_clk_n_out(qkn));
  sdp_ctl_model sdp_ctl_model_inst (
    .clk_in(clk), .cmd_out(pins), .wclk_out(wclk), .wdata_out(wd), .wmask_out(wm));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [2:0] c, b, input logic [19:0] a,
                    input logic [17:0] d0, d1, input logic m0, m1);
    sdp_ctl_model_inst.cmd(c, b, a);
    repeat (3) @(posedge clk);
    #7 sdp_ctl_model_inst.pair(d0, d1, m0, m1);
    repeat (8) @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] b, input logic [19:0] a);
    int n;
    got.delete();
    sdp_ctl_model_inst.cmd(3'h3, b, a);
    n = 0;
    while (rv !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    chk(n == 4, "read latency");
    while (rv === 1'b1 && got.size() < 12) begin
      got.push_back(rd_q);
      @(negedge clk);
    end
  endtask
  task automatic ex2(input logic [17:0] a, b);
    chk(got.size() == 2 && got[0] === a && got[1] === b, "read data");
  endtask
  task automatic t_basic();
    wr(3'h1, 3'h1, 20'h5, A, B, 1'b0, 1'b0);
    rd(3'h1, 20'h5);
    ex2(A, B);
  endtask
  task automatic t_mask();
    wr(3'h1, 3'h1, 20'h5, C, D, 1'b1, 1'b0);
    rd(3'h1, 20'h5);
    ex2(A, D);
    wr(3'h1, 3'h3, 20'h10, G, H, 1'b0, 1'b0);
    wr(3'h1, 3'h3, 20'h10, C, D, 1'b0, 1'b1);
    rd(3'h3, 20'h10);
    ex2(C, H);
  endtask
  task automatic t_bank();
    wr(3'h1, 3'h2, 20'h5, E, F, 1'b0, 1'b0);
    rd(3'h1, 20'h5);
    ex2(A, D);
    rd(3'h2, 20'h5);
    ex2(E, F);
  endtask
  task automatic t_ignore();
    sdp_ctl_model_inst.cmd(3'h7, 3'h1, 20'h5);
    sdp_ctl_model_inst.cmd(3'h2, 3'h1, 20'h5);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      chk(rv === 1'b0, "ignored command answered");
    end
    wr(3'h5, 3'h1, 20'h5, G, H, 1'b0, 1'b0);
    rd(3'h1, 20'h5);
    ex2(A, D);
  endtask
  task automatic t_modes();
    logic [1:0] code [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    int len [4] = '{4, 8, 8, 2};
    for (int i = 0; i < 4; i++) begin
      sdp_ctl_model_inst.cmd(3'h0, 3'h0, {15'h0, code[i], 3'h0});
      repeat (3) @(posedge clk);
      rd(3'h1, 20'h4);
      chk(got.size() == len[i] && got[1] === A, "burst length");
    end
  endtask
  initial begin
    #60000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(qk === 2'h0 && qkn === 2'h3 && rv === 1'b0 && rd_q === 18'h0, "reset");
    @(posedge clk);
    rstn <= 1'b1;
    t_basic();
    t_mask();
    t_bank();
    t_ignore();
    t_modes();
    print_verdict();
  end
endmodule
